// ==== verilog/itb_regs.vh ====
/*
 Holds the register offsets, field positions, reset values and codes of the
 instruction tag and breakpoint-low block.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef ITB_REGS_VH
`define ITB_REGS_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
// Byte address is the register index times four
`define ITB_BRK_DATA_LOW_OFS 8'h94
`define ITB_INDEX_SCALE 4
`define ITB_BRK_DATA_LOW_IDX 8'h25
`define ITB_CTRL_OFS 8'h00
`define ITB_STATUS_OFS 8'h04
`define ITB_MATCH_OFS 8'h08
`define ITB_ADDR_W 8
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ITB_CTRL_MODE_LSB 0
`define ITB_CTRL_MODE_MSB 1
`define ITB_CTRL_DCE_BIT 2
`define ITB_CTRL_RANGE_BIT 3
`define ITB_CTRL_MASK_BIT 4
`define ITB_CTRL_W 5
// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define ITB_ST_TAGGING_BIT 0
`define ITB_ST_DEBUG_BIT 1
`define ITB_ST_MATCH_BIT 2
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ITB_BRK_DATA_LOW_RST 8'h00
`define ITB_CTRL_RST 5'h00
// ----------------------------------------------------------------
// Breakpoint modes
// ----------------------------------------------------------------
`define ITB_MODE_OFF 2'h0
`define ITB_MODE_SWI_DUAL 2'h1
`define ITB_MODE_FULL 2'h2
`define ITB_MODE_BDM_DUAL 2'h3
// ----------------------------------------------------------------
// Tag codes, one bit per byte lane
// ----------------------------------------------------------------
`define ITB_TAG_NONE 2'h0
`define ITB_TAG_LO_BIT 0
`define ITB_TAG_HI_BIT 1
// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define ITB_RESP_OKAY 2'h0
`define ITB_RESP_SLVERR 2'h2
`endif

// ==== verilog/itb_tag_break.v ====
/*
 Holds the instruction tag capture, tagged instruction queue and low-byte
 breakpoint data comparator, with an AXI4-Lite register slave.
 Assumes the CPU fetch, queue advance and debug command sources run on aclk
 and that bus_clock, tag_low_n and tag_high_n arrive from pins asynchronously.
*/
// Chosen here: register access over AXI4-Lite.
`include "itb_regs.vh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RULE1] Low data byte compares data bus, or address low byte in dual modes.
// [RULE2] Mode, data compare enable, range control and low mask gate the compare.
// [RULE3] Tag pins become tag inputs only after the tag-go command.
// [RULE4] Low tag shares the low strobe pin, high tag the debug serial pin.
// [RULE5] Both tags are sampled at each falling edge of the bus clock.
// [RULE6] Each tag pin acts alone, never changing the other's effect.
// [RULE7] Tags are active low; each low pin tags its own byte.
// [RULE8] Tagging works in every operating mode, no mode gate.
// [RULE9] Tagging switches off once background debug mode becomes active.
// [RULE10] Serial debug commands are ignored while tagging is active.
// [RULE11] Captured tags ride with their fetched bytes through the queue.
// [RULE12] Tagged instruction at queue head enters debug mode, not executed.
// [RULE13] High tag marks upper lane byte, low tag marks lower lane byte.
module itb_tag_break #(
   parameter QUEUE_DEPTH = 3
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire bus_clock,
   input wire tag_low_n,
   input wire tag_high_n,
   input wire tag_go_command,
   input wire dbg_cmd_valid,
   output wire dbg_cmd_accept,
   output wire tag_pins_enabled,
   input wire fetch_valid,
   input wire [15:0] fetch_data,
   input wire queue_advance,
   input wire queue_flush,
   output wire [7:0] queue_head_byte,
   output wire head_valid,
   output wire head_execute,
   output reg background_debug_mode_r,
   input wire debug_exit,
   input wire [15:0] cpu_addr,
   input wire [15:0] cpu_data,
   input wire cpu_bus_valid,
   output reg low_byte_match_r
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree
   reg [2:0] bus_clock_s_r;
   reg [2:0] tlo_s_r;
   reg [2:0] thi_s_r;
   reg bus_clock_q_r;
   reg tlo_q_r;
   reg thi_q_r;
   reg tagging_r;
   reg [1:0] tag_pend_r;
   wire bus_clock_fall;

   always @(posedge aclk) begin
      if (!aresetn) begin
         bus_clock_s_r <= 3'h0;
         tlo_s_r <= 3'h7;
         thi_s_r <= 3'h7;
         bus_clock_q_r <= 1'b0;
         tlo_q_r <= 1'b1;
         thi_q_r <= 1'b1;
      end else begin
         bus_clock_s_r <= {bus_clock_s_r[1:0], bus_clock};
         tlo_s_r <= {tlo_s_r[1:0], tag_low_n};
         thi_s_r <= {thi_s_r[1:0], tag_high_n};
         if (bus_clock_s_r[1] == bus_clock_s_r[2]) begin
            bus_clock_q_r <= bus_clock_s_r[2];
         end
         if (tlo_s_r[1] == tlo_s_r[2]) begin
            tlo_q_r <= tlo_s_r[2];
         end
         if (thi_s_r[1] == thi_s_r[2]) begin
            thi_q_r <= thi_s_r[2];
         end
      end
   end

   assign bus_clock_fall = bus_clock_q_r && (bus_clock_s_r[1] == bus_clock_s_r[2]) && !bus_clock_s_r[2]; // RULE5

   // ----------------------------------------------------------------
   // Tagging control
   // ----------------------------------------------------------------
   // No operating mode input exists here, so tagging is never mode gated
   assign tag_pins_enabled = tagging_r; // RULE4 RULE8
   assign dbg_cmd_accept = dbg_cmd_valid && !tagging_r; // RULE10

   always @(posedge aclk) begin
      if (!aresetn) begin
         tagging_r <= 1'b0;
         tag_pend_r <= `ITB_TAG_NONE;
      end else begin
         if (background_debug_mode_r) begin
            tagging_r <= 1'b0; // RULE9
         end else if (tag_go_command && !tagging_r) begin
            tagging_r <= 1'b1; // RULE3
         end
         if (!tagging_r || background_debug_mode_r) begin
            tag_pend_r <= `ITB_TAG_NONE;
         end else if (bus_clock_fall) begin
            // Each lane latched from its own pin only
            tag_pend_r[`ITB_TAG_LO_BIT] <= !tlo_q_r; // RULE6 RULE7
            tag_pend_r[`ITB_TAG_HI_BIT] <= !thi_q_r; // RULE6 RULE7
         end else if (fetch_valid) begin
            tag_pend_r <= `ITB_TAG_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Instruction queue with tag bits
   // ----------------------------------------------------------------
   // Byte queue; a fetch pushes upper lane first, then lower lane
   localparam QW = 2 * QUEUE_DEPTH;
   reg [7:0] q_byte_r [0:QW-1];
   reg [QW-1:0] q_tag_r;
   reg [QW-1:0] q_vld_r;
   wire [1:0] fetch_tag;
   integer i;
   integer j;
   integer wp;

   assign fetch_tag = tagging_r ? tag_pend_r : `ITB_TAG_NONE;
   assign queue_head_byte = q_byte_r[0];
   assign head_valid = q_vld_r[0];
   assign head_execute = q_vld_r[0] && !q_tag_r[0] && !background_debug_mode_r; // RULE12

   // Free slot after this cycle's advance; a fetch lands there
   always @* begin
      wp = 0;
      for (j = 0; j < QW; j = j + 1) begin
         if (q_vld_r[j]) begin
            wp = j + 1;
         end
      end
      if (queue_advance && head_execute && wp > 0) begin
         wp = wp - 1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || queue_flush) begin
         q_vld_r <= {QW{1'b0}};
         q_tag_r <= {QW{1'b0}};
         for (i = 0; i < QW; i = i + 1) begin
            q_byte_r[i] <= 8'h00;
         end
      end else begin
         // Shift out the head on advance; tags move with bytes
         if (queue_advance && head_execute) begin
            for (i = 0; i < QW - 1; i = i + 1) begin
               q_byte_r[i] <= q_byte_r[i+1]; // RULE11
               q_tag_r[i] <= q_tag_r[i+1]; // RULE11
               q_vld_r[i] <= q_vld_r[i+1];
            end
            q_vld_r[QW-1] <= 1'b0;
            q_tag_r[QW-1] <= 1'b0;
         end
         // A fetch that finds no room for both lanes is dropped
         if (fetch_valid && wp <= QW - 2) begin
            q_byte_r[wp] <= fetch_data[15:8]; // RULE13
            q_tag_r[wp] <= fetch_tag[`ITB_TAG_HI_BIT]; // RULE13
            q_vld_r[wp] <= 1'b1;
            q_byte_r[wp+1] <= fetch_data[7:0]; // RULE13
            q_tag_r[wp+1] <= fetch_tag[`ITB_TAG_LO_BIT]; // RULE13
            q_vld_r[wp+1] <= 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         background_debug_mode_r <= 1'b0;
      end else if (q_vld_r[0] && q_tag_r[0]) begin
         background_debug_mode_r <= 1'b1; // RULE12
      end else if (debug_exit) begin
         background_debug_mode_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Low byte comparator
   // ----------------------------------------------------------------
   reg [7:0] brk_data_low_r;
   reg [`ITB_CTRL_W-1:0] ctrl_r;
   reg match_seen_r;
   wire [1:0] mode;
   wire dual_mode;
   wire [7:0] cmp_src;
   wire cmp_used;

   assign mode = ctrl_r[`ITB_CTRL_MODE_MSB:`ITB_CTRL_MODE_LSB];
   assign dual_mode = (mode == `ITB_MODE_SWI_DUAL) || (mode == `ITB_MODE_BDM_DUAL);
   assign cmp_src = dual_mode ? cpu_addr[7:0] : cpu_data[7:0]; // RULE1
   // Dual uses range control; full mode uses the low mask
   assign cmp_used = (mode != `ITB_MODE_OFF) && ctrl_r[`ITB_CTRL_DCE_BIT]
      && (dual_mode ? ctrl_r[`ITB_CTRL_RANGE_BIT] : !ctrl_r[`ITB_CTRL_MASK_BIT]); // RULE2

   always @(posedge aclk) begin
      if (!aresetn) begin
         low_byte_match_r <= 1'b0;
      end else begin
         low_byte_match_r <= cpu_bus_valid && cmp_used && (cmp_src == brk_data_low_r); // RULE1
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   // One write and one read in flight; address and data taken in any order
   reg aw_have_r;
   reg w_have_r;
   reg [7:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   wire do_write;

   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_have_r && w_have_r;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ITB_RESP_OKAY;
         brk_data_low_r <= `ITB_BRK_DATA_LOW_RST;
         ctrl_r <= `ITB_CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ITB_RESP_OKAY;
            if (aw_addr_r[7:2] == `ITB_BRK_DATA_LOW_OFS >> 2) begin
               if (w_strb_r[0]) begin
                  brk_data_low_r <= w_data_r[7:0];
               end
            end else if (aw_addr_r[7:2] == `ITB_CTRL_OFS >> 2) begin
               if (w_strb_r[0]) begin
                  ctrl_r <= w_data_r[`ITB_CTRL_W-1:0];
               end
            end else if ((aw_addr_r[7:2] != `ITB_STATUS_OFS >> 2)
               && (aw_addr_r[7:2] != `ITB_MATCH_OFS >> 2)) begin
               s_axi_bresp <= `ITB_RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Sticky match flag; a new match wins over the read that clears it
   wire match_rd;
   assign match_rd = s_axi_arvalid && s_axi_arready
      && (s_axi_araddr[7:2] == `ITB_MATCH_OFS >> 2);

   always @(posedge aclk) begin
      if (!aresetn) begin
         match_seen_r <= 1'b0;
      end else if (low_byte_match_r) begin
         match_seen_r <= 1'b1;
      end else if (match_rd) begin
         match_seen_r <= 1'b0;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ITB_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ITB_RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         if (s_axi_araddr[7:2] == `ITB_BRK_DATA_LOW_OFS >> 2) begin
            s_axi_rdata <= {24'h000000, brk_data_low_r};
         end else if (s_axi_araddr[7:2] == `ITB_CTRL_OFS >> 2) begin
            s_axi_rdata <= {27'h0000000, ctrl_r};
         end else if (s_axi_araddr[7:2] == `ITB_STATUS_OFS >> 2) begin
            s_axi_rdata <= {29'h00000000, low_byte_match_r, background_debug_mode_r,
               tagging_r};
         end else if (s_axi_araddr[7:2] == `ITB_MATCH_OFS >> 2) begin
            s_axi_rdata <= {31'h00000000, match_seen_r};
         end else begin
            s_axi_rresp <= `ITB_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // itb_tag_break

`default_nettype wire

// ==== tb/itb_tag_break_properties.sv ====
/*
 Checker for the tag, debug and compare ports of itb_tag_break.
 Assumes it is bound to that module; one clock, aclk, sync reset aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module itb_tag_break_checker #(
   parameter QUEUE_DEPTH = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tag_go_command,
   input wire logic dbg_cmd_valid,
   input wire logic dbg_cmd_accept,
   input wire logic tag_pins_enabled,
   input wire logic queue_flush,
   input wire logic head_valid,
   input wire logic head_execute,
   input wire logic background_debug_mode_r,
   input wire logic debug_exit,
   input wire logic cpu_bus_valid,
   input wire logic low_byte_match_r
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_cmd_refused: assert property (dbg_cmd_valid && tag_pins_enabled |-> !dbg_cmd_accept)
      else $error("debug command taken while tagging");
   a_tag_go_arms: assert property (tag_go_command && !background_debug_mode_r && !head_valid
      |=> tag_pins_enabled)
      else $error("tag-go did not enable the tag pins");
   a_pins_stay_off: assert property (!tag_pins_enabled && !tag_go_command |=> !tag_pins_enabled)
      else $error("tag pins enabled without tag-go");
   a_tag_off_debug: assert property (background_debug_mode_r && !tag_go_command
      |=> !tag_pins_enabled)
      else $error("tagging still on in debug mode");
   a_debug_no_exec: assert property (background_debug_mode_r |-> !head_execute)
      else $error("head executes in debug mode");
   a_tagged_head: assert property (head_valid && !head_execute && !background_debug_mode_r
      && !queue_flush && !debug_exit |=> background_debug_mode_r)
      else $error("tagged head did not enter debug mode");
   a_debug_holds: assert property (background_debug_mode_r && !debug_exit
      |=> background_debug_mode_r)
      else $error("debug mode left without exit");
   a_match_cause: assert property (low_byte_match_r |-> $past(cpu_bus_valid))
      else $error("match without a bus sample");
   c_refused: cover property (dbg_cmd_valid && tag_pins_enabled);
   c_debug: cover property ($rose(background_debug_mode_r));
   c_match: cover property (low_byte_match_r);
endmodule // itb_tag_break_checker
bind itb_tag_break itb_tag_break_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk_i (.*);
`default_nettype wire

// ==== tb/itb_tag_tool.sv ====
/*
 Model of the development tool that drives the tag pins.
 Assumes aclk from the bench; bus clock runs free at one eighth of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module itb_tag_tool (
   input wire logic aclk,
   input wire logic [1:0] tag_req,
   output logic bus_clock,
   // Idle pins rest high, as the shared strobe and debug pins are pulled up
   output logic tag_high_n = 1'h1,
   output logic tag_low_n = 1'h1
);
   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   logic [2:0] phase_r = 3'h0;
   assign bus_clock = phase_r[2];
   always @(posedge aclk) begin
      phase_r <= phase_r + 3'h1;
      // Levels change mid low phase, far from the fall that samples them
      if (phase_r == 3'h1) begin
         {tag_high_n, tag_low_n} <= ~tag_req;
      end
   end
endmodule // itb_tag_tool
`default_nettype wire

// ==== tb/itb_tag_break_tb.sv ====
/*
 Self-checking bench for itb_tag_break: register, compare and tag scenarios.
 Assumes the checker binds itself and itb_tag_tool drives the tag pins.
*/
`include "itb_regs.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module itb_tag_break_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   logic tag_go_command = 1'h0, dbg_cmd_valid = 1'h0, fetch_valid = 1'h0;
   logic queue_advance = 1'h0, queue_flush = 1'h0, debug_exit = 1'h0, cpu_bus_valid = 1'h0;
   logic [15:0] fetch_data = 16'h0, cpu_addr = 16'h0, cpu_data = 16'h0;
   logic [1:0] tag_req = 2'h0;
   wire bus_clock, tag_low_n, tag_high_n, dbg_cmd_accept, tag_pins_enabled;
   wire head_valid, head_execute, background_debug_mode_r, low_byte_match_r;
   wire [7:0] queue_head_byte;
   integer err_count = 0, n_checks = 0, seed = 32'hC258;
   logic [1:0] resp;
   logic [31:0] rd;
   logic ta, tw, done;
   always #12.5 aclk = ~aclk;
   itb_tag_break #(.QUEUE_DEPTH(3)) itb_tag_break_i (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
      .s_axi_wstrb(4'hF), .*);
   itb_tag_tool itb_tag_tool_i (.*);
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input [31:0] g, input [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task stop_test;
      begin
         if (err_count == 0 && n_checks > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   // Each channel is released only at the edge that takes it
   task axw(input [7:0] a, input [31:0] d);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         done = 1'h0;
         while (!done) begin
            @(negedge aclk);
            done = s_axi_bvalid;
            resp = s_axi_bresp;
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
         end
         s_axi_bready <= 1'h0;
         // Let an edge pass so a next call never re-drives in this step
         @(posedge aclk);
      end
   endtask
   task axr(input [7:0] a);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         done = 1'h0;
         while (!done) begin
            @(negedge aclk);
            done = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            ta = s_axi_arvalid & s_axi_arready;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
         end
         s_axi_rready <= 1'h0;
         @(posedge aclk);
      end
   endtask
   // Full mode compares the data lane, dual modes the address lane
   function logic exp_match(input [4:0] c, input logic on_addr);
      begin
         if (!c[2] || c[1:0] == `ITB_MODE_OFF) exp_match = 1'h0;
         else if (c[1:0] == `ITB_MODE_FULL) exp_match = !on_addr && !c[4];
         else exp_match = on_addr && c[3];
      end
   endfunction
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin : main
      integer c, k;
      logic [7:0] d;
      logic [31:0] w;
      logic [1:0] tg;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axr(`ITB_BRK_DATA_LOW_OFS);
      `CHK(rd, `ITB_BRK_DATA_LOW_RST);
      w = $random(seed);
      axw(`ITB_BRK_DATA_LOW_OFS, w);
      `CHK(resp, `ITB_RESP_OKAY);
      axr(`ITB_BRK_DATA_LOW_OFS);
      `CHK(rd, {24'h0, w[7:0]});
      axr(8'h0C);
      `CHK(resp, `ITB_RESP_SLVERR);
      axw(8'h0C, w);
      `CHK(resp, `ITB_RESP_SLVERR);
      for (c = 0; c < 64; c = c + 1) begin
         d = $random(seed);
         w = $random(seed);
         axw(`ITB_BRK_DATA_LOW_OFS, {24'h0, d});
         axw(`ITB_CTRL_OFS, {27'h0, c[4:0]});
         cpu_addr <= {w[15:8], c[5] ? d : ~d};
         cpu_data <= {w[31:24], c[5] ? ~d : d};
         cpu_bus_valid <= 1'h1;
         @(posedge aclk);
         cpu_bus_valid <= 1'h0;
         repeat (2) @(posedge aclk);
         axr(`ITB_MATCH_OFS);
         `CHK(rd != 32'h0, exp_match(c[4:0], c[5]));
      end
      // Reset in mid-run must bring the registers back
      axw(`ITB_BRK_DATA_LOW_OFS, 32'hA5);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axr(`ITB_BRK_DATA_LOW_OFS);
      `CHK(rd, `ITB_BRK_DATA_LOW_RST);
      axr(`ITB_CTRL_OFS);
      `CHK(rd, `ITB_CTRL_RST);
      for (k = 0; k < 8; k = k + 1) begin
         tg = k[1:0];
         tag_go_command <= 1'h1;
         dbg_cmd_valid <= 1'h1;
         @(posedge aclk);
         tag_go_command <= 1'h0;
         tag_req <= tg;
         @(negedge aclk);
         `CHK({tag_pins_enabled, dbg_cmd_accept}, 2'h2);
         repeat (2) @(negedge bus_clock);
         repeat (7) @(posedge aclk);
         w = $random(seed);
         fetch_data <= w[15:0];
         fetch_valid <= 1'h1;
         tag_req <= 2'h0;
         @(posedge aclk);
         fetch_valid <= 1'h0;
         repeat (3) @(posedge aclk);
         @(negedge aclk);
         `CHK({queue_head_byte, head_valid, background_debug_mode_r, head_execute,
            dbg_cmd_accept},
            {w[15:8], 1'h1, tg[1], !tg[1], tg[1]});
         @(posedge aclk);
         axr(`ITB_STATUS_OFS);
         `CHK(rd, 32'h1 << (tg[1] ? `ITB_ST_DEBUG_BIT : `ITB_ST_TAGGING_BIT));
         if (!tg[1]) begin
            @(posedge aclk);
            queue_advance <= 1'h1;
            @(posedge aclk);
            queue_advance <= 1'h0;
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            `CHK({queue_head_byte, head_valid, background_debug_mode_r, head_execute},
               {w[7:0], 1'h1, tg[0], !tg[0]});
         end
         // Flush before leaving debug: a tagged head would pull it straight back
         @(posedge aclk);
         queue_flush <= 1'h1;
         dbg_cmd_valid <= 1'h0;
         @(posedge aclk);
         queue_flush <= 1'h0;
         debug_exit <= 1'h1;
         @(posedge aclk);
         debug_exit <= 1'h0;
      end
      stop_test;
   end
   initial begin : watchdog
      repeat (5000) @(posedge aclk);
      err_count = err_count + 1;
      stop_test;
   end
endmodule // itb_tag_break_tb
`default_nettype wire
